/* File: core/sfr_core_defines.svh */
/*
  Offsets, reset values, field positions and sizes for the core special
  registers. Assumes inclusion by bare name from the core design files.
*/
`ifndef SFR_CORE_DEFINES_SVH
`define SFR_CORE_DEFINES_SVH

`define SFR_ADDR_STACK 8'h81
`define SFR_ADDR_DATA_POINTER_LO 8'h82
`define SFR_ADDR_DATA_POINTER_HI 8'h83
`define SFR_ADDR_PORT_ONE 8'h90
`define SFR_ADDR_STATUS 8'hD0
`define SFR_ADDR_ACC 8'hE0
`define SFR_ADDR_SECOND 8'hF0
`define SFR_ADDR_PORT_ZERO 8'h80

`define RST_STACK 8'h07
`define RST_DATA_POINTER_BYTE 8'h00
`define RST_PORT 8'hFF
`define RST_STATUS 8'h00
`define RST_ACC 8'h00
`define RST_SECOND 8'h00

`define PSW_CARRY_BIT 7
`define PSW_HALF_BIT 6
`define PSW_UF0_BIT 5
`define PSW_BANK_HI 4
`define PSW_BANK_LO 3
`define PSW_OV_BIT 2
`define PSW_UF1_BIT 1
`define PSW_PARITY_BIT 0

`define BANK_SIZE_LOG2 3

`endif

/* File: core/sfr_core_pkg.sv */
/*
  Types shared by the core special register file.
  Assumes a single clock domain and the execution unit as sole client.
*/
package sfr_core_pkg;

  // Arithmetic unit flag update request
  typedef struct packed {
    logic carry_we;
    logic carry;
    logic half_we;
    logic half;
    logic ov_we;
    logic ov;
  } flag_upd_t;

  // Special-function bus request from the execution unit
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_val;
  } sfr_req_t;

endpackage

/* File: core/cpu_core_special_registers.sv */
/*
  Core special registers: accumulator, second arithmetic register, status
  word, stack pointer, data pointer and the port zero/one output latches.
  Assumes the execution unit drives one request per cycle on sys_clk and
  sequences pushes, calls and arithmetic itself; pads are external.
  Port zero needs external pull-ups; port one pads carry their own.
  Port reads return the synchronised pad level, not the latch.
*/
`timescale 1ns/10ps
`include "sfr_core_defines.svh"

// How it works
// - Accumulator at E0h, resets to zero, holds most instruction operands.
// - Second arithmetic register at F0h: multiply, divide, scratch data.
// - Status at D0h: carry, half carry, flag0, bank, overflow, flag1, parity.
// - Bank field selects working registers at 00h, 08h, 10h or 18h.
// - Parity kept even with accumulator by hardware; writes ignored.
// - Stack pointer resets to 07h, pre-increments on push and call.
// - Stack pointer always gives scratchpad address of current stack top.
// - Data pointer low 82h, high 83h, zero reset, word or byte loads.
// - Data pointer supplies address for code reads and external moves.
// - Two user flags store software values with no side effects.
// - Port latches reset to FFh and accept single-bit writes.
// - Port zero only sinks; other ports rely on internal pull-ups.
module cpu_core_special_registers (
  input wire logic sys_clk, // 250 MHz core clock
  input wire logic reset_n, // Asynchronous reset, active low
  input sfr_core_pkg::sfr_req_t req, // Special-function bus request
  output logic [7:0] rdata_q, // Read data, one cycle after rd
  output logic rvalid_q, // Read data valid pulse
  input wire logic acc_we, // Execution unit accumulator load
  input wire logic [7:0] acc_wdata, // Accumulator load value
  input wire logic second_we, // Execution unit second register load
  input wire logic [7:0] second_wdata, // Second register load value
  input sfr_core_pkg::flag_upd_t flag_upd, // Arithmetic flag updates
  input wire logic stack_push, // Push or call: pre-increment
  input wire logic stack_pop, // Pop or return: post-decrement
  input wire logic data_pointer_we, // Sixteen-bit data pointer load
  input wire logic [15:0] data_pointer_wdata, // Data pointer load value
  input wire logic data_pointer_inc, // Data pointer increment
  input wire logic [7:0] port_zero_pin_i, // Port zero pad level
  input wire logic [7:0] port_one_pin_i, // Port one pad level
  output logic [7:0] accumulator_q, // Accumulator contents
  output logic [7:0] second_q, // Second arithmetic register
  output logic [7:0] status_q, // Status word incl. live parity
  output logic [7:0] stack_top_q, // Stack top scratchpad address
  output logic [15:0] data_pointer_q, // Data pointer for indexed access
  output logic [7:0] bank_base_q, // Working register bank base
  output logic [7:0] port_zero_o, // Port zero output level (always 0)
  output logic [7:0] port_zero_oe, // Port zero drive enable (sink)
  output logic [7:0] port_one_q // Port one latch to pull-up pads
);

  logic [7:0] acc_q;
  logic [7:0] b_q;
  logic carry_q, half_q, uf0_q, ov_q, uf1_q;
  logic [1:0] bank_q;
  logic [7:0] sp_q;
  logic [7:0] dpl_q, dph_q;
  logic [7:0] p0_q, p1_q;
  logic [7:0] p0_s1_q, p0_s2_q, p1_s1_q, p1_s2_q;
  logic [7:0] psw_view;
  logic [7:0] psw_merged;
  logic parity_now;
  logic sw_wr;

  // Byte or single-bit write merge for bit-addressable registers
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input sfr_core_pkg::sfr_req_t r);
    logic [7:0] v;
    v = old;
    if (r.bit_wr) begin
      v[r.bit_sel] = r.bit_val;
    end else begin
      v = r.wdata;
    end
    return v;
  endfunction

  // True when software writes the given address this cycle
  function automatic logic hit(input sfr_core_pkg::sfr_req_t r,
                               input logic [7:0] a);
    return (r.wr | r.bit_wr) && (r.addr == a);
  endfunction

  assign sw_wr = req.wr | req.bit_wr;
  assign parity_now = ^acc_q;

  // Status value a software store would leave; parity is dropped later
  assign psw_merged = merge(psw_view, req);

  // Status word view; parity is never a stored software value
  always_comb begin
    psw_view = 8'h00;
    psw_view[`PSW_CARRY_BIT] = carry_q;
    psw_view[`PSW_HALF_BIT] = half_q;
    psw_view[`PSW_UF0_BIT] = uf0_q;
    psw_view[`PSW_BANK_HI:`PSW_BANK_LO] = bank_q;
    psw_view[`PSW_OV_BIT] = ov_q;
    psw_view[`PSW_UF1_BIT] = uf1_q;
    psw_view[`PSW_PARITY_BIT] = parity_now;
  end

  // Accumulator; software write wins over execution unit load in one cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= `RST_ACC;
    end else if (hit(req, `SFR_ADDR_ACC)) begin
      acc_q <= merge(acc_q, req);
    end else if (acc_we) begin
      acc_q <= acc_wdata;
    end
  end

  // Second arithmetic register for multiply and divide results
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      b_q <= `RST_SECOND;
    end else if (hit(req, `SFR_ADDR_SECOND)) begin
      b_q <= merge(b_q, req);
    end else if (second_we) begin
      b_q <= second_wdata;
    end
  end

  // Status flags; arithmetic updates land after a software write so an
  // instruction result is never lost to a same-cycle store
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {carry_q, half_q, uf0_q, ov_q, uf1_q} <= 5'h00;
      bank_q <= 2'h0;
    end else begin
      if (hit(req, `SFR_ADDR_STATUS)) begin
        uf0_q <= psw_merged[`PSW_UF0_BIT];
        uf1_q <= psw_merged[`PSW_UF1_BIT];
        bank_q <= psw_merged[`PSW_BANK_HI:`PSW_BANK_LO];
        carry_q <= flag_upd.carry_we ? flag_upd.carry
                                     : psw_merged[`PSW_CARRY_BIT];
        half_q <= flag_upd.half_we ? flag_upd.half
                                   : psw_merged[`PSW_HALF_BIT];
        ov_q <= flag_upd.ov_we ? flag_upd.ov
                               : psw_merged[`PSW_OV_BIT];
      end else begin
        if (flag_upd.carry_we) begin
          carry_q <= flag_upd.carry;
        end
        if (flag_upd.half_we) begin
          half_q <= flag_upd.half;
        end
        if (flag_upd.ov_we) begin
          ov_q <= flag_upd.ov;
        end
      end
    end
  end

  // Stack pointer; pre-increment on push so the first byte lands at 08h
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_q <= `RST_STACK;
    end else if (hit(req, `SFR_ADDR_STACK)) begin
      sp_q <= merge(sp_q, req);
    end else if (stack_push && !stack_pop) begin
      sp_q <= sp_q + 8'h01;
    end else if (stack_pop && !stack_push) begin
      sp_q <= sp_q - 8'h01;
    end
  end

  // Data pointer: byte stores via the bus, word load or increment directly
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dpl_q <= `RST_DATA_POINTER_BYTE;
      dph_q <= `RST_DATA_POINTER_BYTE;
    end else if (data_pointer_we) begin
      {dph_q, dpl_q} <= data_pointer_wdata;
    end else if (hit(req, `SFR_ADDR_DATA_POINTER_LO) ||
                 hit(req, `SFR_ADDR_DATA_POINTER_HI)) begin
      if (hit(req, `SFR_ADDR_DATA_POINTER_LO)) begin
        dpl_q <= merge(dpl_q, req);
      end else begin
        dph_q <= merge(dph_q, req);
      end
    end else if (data_pointer_inc) begin
      {dph_q, dpl_q} <= {dph_q, dpl_q} + 16'h0001;
    end
  end

  // Port zero latch, bit addressable; a one releases the pin
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      p0_q <= `RST_PORT;
    end else if (hit(req, `SFR_ADDR_PORT_ZERO)) begin
      p0_q <= merge(p0_q, req);
    end
  end

  // Port one latch, bit addressable; a single-bit store leaves the rest
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      p1_q <= `RST_PORT;
    end else if (hit(req, `SFR_ADDR_PORT_ONE)) begin
      p1_q <= merge(p1_q, req);
    end
  end

  // Port zero pad level is asynchronous; two flops before any read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      p0_s1_q <= 8'hFF;
      p0_s2_q <= 8'hFF;
    end else begin
      p0_s1_q <= port_zero_pin_i;
      p0_s2_q <= p0_s1_q;
    end
  end

  // Port one pad level, same two-flop guard; reads lag the pin by two
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      p1_s1_q <= 8'hFF;
      p1_s2_q <= 8'hFF;
    end else begin
      p1_s1_q <= port_one_pin_i;
      p1_s2_q <= p1_s1_q;
    end
  end

  // Read valid; a read sharing its cycle with a store is dropped so the
  // caller never sees data whose order against the store is unclear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd && !sw_wr;
    end
  end

  // Read port; ports read pad level, unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      if (!req.rd) begin
        rdata_q <= 8'h00;
      end else if (req.addr == `SFR_ADDR_ACC) begin
        rdata_q <= acc_q;
      end else if (req.addr == `SFR_ADDR_SECOND) begin
        rdata_q <= b_q;
      end else if (req.addr == `SFR_ADDR_STATUS) begin
        rdata_q <= psw_view;
      end else if (req.addr == `SFR_ADDR_STACK) begin
        rdata_q <= sp_q;
      end else if (req.addr == `SFR_ADDR_DATA_POINTER_LO) begin
        rdata_q <= dpl_q;
      end else if (req.addr == `SFR_ADDR_DATA_POINTER_HI) begin
        rdata_q <= dph_q;
      end else if (req.addr == `SFR_ADDR_PORT_ZERO) begin
        rdata_q <= p0_s2_q;
      end else if (req.addr == `SFR_ADDR_PORT_ONE) begin
        rdata_q <= p1_s2_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // Registered views for the datapath. Outputs trail the storage by one
  // cycle; the execution unit must allow for that.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      accumulator_q <= `RST_ACC;
      second_q <= `RST_SECOND;
      status_q <= `RST_STATUS;
      stack_top_q <= `RST_STACK;
      data_pointer_q <= {`RST_DATA_POINTER_BYTE, `RST_DATA_POINTER_BYTE};
    end else begin
      accumulator_q <= acc_q;
      second_q <= b_q;
      status_q <= psw_view;
      stack_top_q <= sp_q;
      data_pointer_q <= {dph_q, dpl_q};
    end
  end

  // Working register bank base: eight registers to a bank, so the bank
  // number sits three bits up
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_base_q <= 8'h00;
    end else begin
      bank_base_q <= {3'h0, bank_q, `BANK_SIZE_LOG2'h0};
    end
  end

  // Pad drives. Port zero never drives high, so its level stays low and
  // only the enable follows the latch; port one relies on pull-ups
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_zero_o <= 8'h00;
      port_zero_oe <= 8'h00;
      port_one_q <= `RST_PORT;
    end else begin
      port_zero_o <= 8'h00;
      port_zero_oe <= ~p0_q;
      port_one_q <= p1_q;
    end
  end

endmodule // cpu_core_special_registers

/* File: test/sfr_core_sva.sv */
/* Checker for the core special register ports.
   Assumes bind onto the register file; one clock domain. */
`timescale 1ns/10ps
module sfr_core_sva (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input sfr_core_pkg::sfr_req_t req, // Bus request
  input wire logic [7:0] rdata_q, // Read data
  input wire logic rvalid_q, // Read valid
  input sfr_core_pkg::flag_upd_t flag_upd, // Flag updates
  input wire logic stack_push, // Push
  input wire logic stack_pop, // Pop
  input wire logic data_pointer_we, // Word load
  input wire logic [15:0] data_pointer_wdata, // Word value
  input wire logic [7:0] accumulator_q, // Accumulator
  input wire logic [7:0] status_q, // Status word
  input wire logic [7:0] stack_top_q, // Stack top
  input wire logic [15:0] data_pointer_q, // Data pointer
  input wire logic [7:0] bank_base_q, // Bank base
  input wire logic [7:0] port_zero_o // Port zero level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Whole-byte write; copies at the ports follow two edges later
  sequence byte_wr(a);
    req.wr && !req.bit_wr && req.addr == a;
  endsequence
  sequence plain_rd;
    req.rd && !req.wr && !req.bit_wr;
  endsequence
  acc_load_a: assert property (
    byte_wr(8'hE0) |-> ##2 accumulator_q == $past(req.wdata, 2))
    else $error("accumulator load lost");
  read_pulse_a: assert property (plain_rd |=> rvalid_q)
    else $error("read gave no valid");
  read_idle_a: assert property (
    !req.rd |=> !rvalid_q && rdata_q == 8'h00)
    else $error("read data without read");
  parity_even_a: assert property (^{accumulator_q, status_q[0]} == 1'b0)
    else $error("parity not even");
  bank_base_a: assert property (
    bank_base_q == {3'b000, status_q[4:3], 3'b000})
    else $error("bank base wrong");
  user_flags_a: assert property (
    byte_wr(8'hD0) |-> ##2 status_q[5] == $past(req.wdata[5], 2)
      && status_q[1] == $past(req.wdata[1], 2))
    else $error("user flag lost");
  carry_upd_a: assert property (
    flag_upd.carry_we |-> ##2 status_q[7] == $past(flag_upd.carry, 2))
    else $error("carry update lost");
  // Bus writes to any byte are excluded; a stack pointer write wins over a push
  stack_pre_inc_a: assert property (
    stack_push && !stack_pop && !req.wr && !req.bit_wr
      |=> ##1 stack_top_q == 8'($past(stack_top_q) + 8'h01))
    else $error("stack not incremented");
  data_pointer_load_a: assert property (
    data_pointer_we |-> ##2 data_pointer_q == $past(data_pointer_wdata, 2))
    else $error("data pointer load lost");
  port_sink_a: assert property (port_zero_o == 8'h00)
    else $error("port zero drove high");
endmodule // sfr_core_sva

bind cpu_core_special_registers sfr_core_sva u_sva (.sys_clk, .reset_n,
  .req, .rdata_q, .rvalid_q, .flag_upd, .stack_push, .stack_pop, .data_pointer_we,
  .data_pointer_wdata, .accumulator_q, .status_q, .stack_top_q, .data_pointer_q,
  .bank_base_q, .port_zero_o);

/* File: test/tb_cpu_core_special_registers.sv */
/* Directed bench for the core special registers.
   Assumes design and checker compiled first; pads follow the latches. */
`timescale 1ns/10ps
module tb_cpu_core_special_registers;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  sfr_core_pkg::sfr_req_t req = '0;
  sfr_core_pkg::flag_upd_t flag_upd = '0;
  logic acc_we = 1'b0;
  logic second_we = 1'b0;
  logic [7:0] acc_wdata = 8'h00;
  logic [7:0] second_wdata = 8'h00;
  logic stack_push = 1'b0;
  logic stack_pop = 1'b0;
  logic data_pointer_we = 1'b0;
  logic data_pointer_inc = 1'b0;
  logic [15:0] data_pointer_wdata = 16'h0000;
  logic [7:0] pad_zero = 8'hFF;
  logic [7:0] pad_one = 8'hFF;
  logic [7:0] rdata_q, accumulator_q, second_q, status_q, stack_top_q;
  logic [7:0] bank_base_q, port_zero_o, port_zero_oe, port_one_q;
  logic [15:0] data_pointer_q;
  logic rvalid_q;
  int num_errors = 0;
  int check_count = 0;
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  cpu_core_special_registers dut (.sys_clk, .reset_n, .req, .rdata_q,
    .rvalid_q, .acc_we, .acc_wdata, .second_we, .second_wdata, .flag_upd,
    .stack_push, .stack_pop, .data_pointer_we, .data_pointer_wdata, .data_pointer_inc,
    .port_zero_pin_i(pad_zero), .port_one_pin_i(pad_one), .accumulator_q,
    .second_q, .status_q, .stack_top_q, .data_pointer_q, .bank_base_q,
    .port_zero_o, .port_zero_oe, .port_one_q);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Bus tasks start at a falling edge and leave one idle cycle after, bit_wr two
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    cyc(1);
    req = '0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    cyc(1);
    check(rdata_q, exp);
    check({7'h00, rvalid_q}, 8'h01);
    req = '0;
    cyc(1);
  endtask
  task automatic bit_wr(input logic [7:0] a, input logic [2:0] b);
    req.bit_wr = 1'b1;
    req.addr = a;
    req.bit_sel = b;
    req.bit_val = 1'b0;
    cyc(1);
    req = '0;
    cyc(2);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog well beyond the under one hundred cycles the tests need
  initial begin
    #40000;
    num_errors++;
    end_of_test();
  end
  // Directed tests
  initial begin
    cyc(10);
    reset_n = 1'b1;
    cyc(1);
    rd(8'h81, 8'h07);
    rd(8'h82, 8'h00);
    rd(8'h83, 8'h00);
    rd(8'hE0, 8'h00);
    rd(8'hF0, 8'h00);
    rd(8'hD0, 8'h00);
    rd(8'h90, 8'hFF);
    rd(8'hA5, 8'h00);
    check(port_one_q, 8'hFF);
    check(port_zero_oe, 8'h00);
    $display("test reset done");
    wr(8'hE0, 8'h55);
    wr(8'hD0, 8'hFF);
    rd(8'hD0, 8'hFE);
    check(bank_base_q, 8'h18);
    wr(8'hE0, 8'h07);
    cyc(1);
    check(status_q, 8'hFF);
    check(accumulator_q, 8'h07);
    for (int i = 0; i < 4; i++) begin
      wr(8'hD0, 8'(i << 3));
      check(status_q, 8'(i << 3) | 8'h01);
      check(bank_base_q, 8'(i * 8));
    end
    flag_upd = '1;
    wr(8'hD0, 8'h00);
    flag_upd = '0;
    cyc(1);
    check(status_q, 8'hC5);
    $display("test status done");
    stack_push = 1'b1;
    cyc(1);
    stack_push = 1'b0;
    cyc(2);
    check(stack_top_q, 8'h08);
    stack_pop = 1'b1;
    cyc(1);
    stack_pop = 1'b0;
    rd(8'h81, 8'h07);
    $display("test stack done");
    data_pointer_we = 1'b1;
    data_pointer_wdata = 16'h1234;
    cyc(1);
    data_pointer_we = 1'b0;
    rd(8'h82, 8'h34);
    rd(8'h83, 8'h12);
    wr(8'h82, 8'hAB);
    data_pointer_inc = 1'b1;
    cyc(1);
    data_pointer_inc = 1'b0;
    cyc(2);
    check(data_pointer_q[7:0], 8'hAC);
    check(data_pointer_q[15:8], 8'h12);
    $display("test pointer done");
    acc_we = 1'b1;
    acc_wdata = 8'h0F;
    second_we = 1'b1;
    second_wdata = 8'h3C;
    cyc(1);
    acc_we = 1'b0;
    second_we = 1'b0;
    rd(8'hE0, 8'h0F);
    rd(8'hF0, 8'h3C);
    wr(8'hF0, 8'hC3);
    check(second_q, 8'hC3);
    bit_wr(8'h90, 3'd3);
    check(port_one_q, 8'hF7);
    pad_one = 8'hF7;
    bit_wr(8'h80, 3'd0);
    check(port_zero_oe, 8'h01);
    check(port_zero_o, 8'h00);
    pad_zero = 8'hFE;
    cyc(2);
    rd(8'h90, 8'hF7);
    rd(8'h80, 8'hFE);
    $display("test ports done");
    pad_zero = 8'hFF;
    pad_one = 8'hFF;
    reset_n = 1'b0;
    cyc(2);
    check(accumulator_q, 8'h00);
    reset_n = 1'b1;
    cyc(1);
    check(port_one_q, 8'hFF);
    check(port_zero_oe, 8'h00);
    rd(8'h81, 8'h07);
    rd(8'h82, 8'h00);
    rd(8'hD0, 8'h00);
    rd(8'h90, 8'hFF);
    $display("test reset again done");
    end_of_test();
  end
endmodule // tb_cpu_core_special_registers
